// >>> verilog/adwc_pkg.sv
// adwc_pkg: device register map, field positions, reset values, host register offsets.
// assumes a 20-bit device address space with byte-wide converter registers.
package adwc_pkg;
  // device register addresses
  localparam logic [19:0] MODE2_ADDR = 20'hf0010;
  localparam logic [19:0] UPPER_ADDR = 20'hf0011;
  localparam logic [19:0] LOWER_ADDR = 20'hf0012;
  localparam logic [19:0] RES_ADDR = 20'hfff1e;
  localparam logic [19:0] RESH_ADDR = 20'hfff1f;
  localparam logic [19:0] CHAN_ADDR = 20'hfff31;
  localparam logic [19:0] TRIGM_ADDR = 20'hfff32;
  // device reset values, mirrored in the host shadows
  localparam logic [7:0] MODE2_RST = 8'h00;
  localparam logic [7:0] UPPER_RST = 8'hff;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] TRIGM_RST = 8'h00;
  // mode2 fields
  localparam int M2_REFP1 = 7;
  localparam int M2_REFP0 = 6;
  localparam int M2_RCK = 3;
  localparam int M2_WAKE = 2;
  localparam int M2_RES8 = 0;
  // channel select fields
  localparam int CH_ISS = 7;
  localparam int CH_RSV_HI = 6;
  localparam int CH_RSV_LO = 5;
  // trigger mode register fields
  localparam int TM_MODE_HI = 7;
  localparam int TM_MODE_LO = 6;
  localparam int TM_ONESHOT = 5;
  localparam logic [1:0] TM_HW_WAIT = 2'h3;
  localparam logic [1:0] REFP_INTERNAL = 2'h2;
  // result layout: 10 result bits left-justified above 6 zero bits
  localparam int RES_LSB = 6;
  // host register offsets
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] CFG_OFS = 8'h0c;
  // command targets
  localparam logic [3:0] T_MODE2 = 4'h0;
  localparam logic [3:0] T_UPPER = 4'h1;
  localparam logic [3:0] T_LOWER = 4'h2;
  localparam logic [3:0] T_CHAN = 4'h3;
  localparam logic [3:0] T_MODE1 = 4'h4;
  localparam logic [3:0] T_TRIGM = 4'h5;
  localparam logic [3:0] T_PORT = 4'h6;
  localparam logic [3:0] T_STOP = 4'h7;
  localparam logic [3:0] T_TRIG = 4'h8;
  // timing counts in clk_sys cycles
  localparam int ACC_HOLD_CYC = 6;
  localparam logic [15:0] TRIG_BASE_CYC = 16'h0064;
  localparam logic [15:0] TRIG_EXTRA_CYC = 16'h0002;
  localparam logic [15:0] TRIG_GAP_DEF = TRIG_BASE_CYC + TRIG_EXTRA_CYC;
endpackage : adwc_pkg

// >>> verilog/adwc_sync.sv
// adwc_sync: three-stage synchroniser for pin inputs, change taken when stages 2 and 3 agree.
// assumes inputs are quasi-static compared with clk_sys.
`timescale 1ns/10ps
module adwc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic [WIDTH-1:0] din, // asynchronous pin level
  output logic [WIDTH-1:0] dout // filtered level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign dout = out_q;
endmodule : adwc_sync

// >>> verilog/adwc_dev_port.sv
// adwc_dev_port: drives one device register access on the pins and holds it for a fixed time.
// assumes the device answers a read within the hold time; read data are resynchronised.
`timescale 1ns/10ps
module adwc_dev_port #(
  parameter int HOLD = adwc_pkg::ACC_HOLD_CYC
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic start, // one-cycle access request
  input wire logic is_rd, // request is a read
  input wire logic [19:0] addr, // device address
  input wire logic [15:0] wdata, // device write data
  output logic busy, // access in progress
  output logic done, // one-cycle end of access
  output logic [15:0] rdata, // captured read data
  output logic [19:0] dev_addr, // address pins
  output logic [15:0] dev_wdata, // write data pins
  output logic dev_wr, // write enable pin
  output logic dev_rd, // read enable pin
  input wire logic [15:0] dev_rdata // read data pins
);
  logic [7:0] cnt_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  logic wr_q;
  logic rd_q;
  logic done_q;
  logic [15:0] rdata_q;
  logic [15:0] rd_sync;
  logic last;

  // read data cross through the three-stage filter; hold covers its delay
  adwc_sync #(.WIDTH(16)) u_rsync (
    .clk_sys(clk_sys),
    .srst(srst),
    .din(dev_rdata),
    .dout(rd_sync)
  );

  assign last = (cnt_q == 8'h01);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q <= 8'h00;
      addr_q <= 20'h00000;
      wdata_q <= 16'h0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      if (start && cnt_q == 8'h00) begin
        cnt_q <= 8'(HOLD);
        addr_q <= addr;
        wdata_q <= wdata;
        wr_q <= !is_rd;
        rd_q <= is_rd;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        if (last) begin
          wr_q <= 1'b0;
          rd_q <= 1'b0;
          done_q <= 1'b1;
          if (rd_q) begin
            rdata_q <= rd_sync;
          end
        end
      end
    end
  end

  assign busy = (cnt_q != 8'h00);
  assign done = done_q;
  assign rdata = rdata_q;
  assign dev_addr = addr_q;
  assign dev_wdata = wdata_q;
  assign dev_wr = wr_q;
  assign dev_rd = rd_q;

  strobe_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(dev_wr) |-> dev_wr [*6])
    else $error("device write strobe shorter than hold time");
endmodule : adwc_dev_port

// >>> verilog/adwc_ctrl.sv
// adwc_ctrl: host controller that programs the converter and collects checked results.
// assumes device status pins run, power and done-irq, and a register access port.
//
// Contract
// - second mode register written only while run and power are both off.
// - wake enable only with hardware trigger wait mode, never sequential mode.
// - wake enable only when clock comes from the high-speed on-chip oscillator.
// - trigger interval in wake mode at least the summed wake and conversion times.
// - wake enable zero in normal operation, set before stop, cleared after resume.
// - read the finished result before writing mode, channel or port registers.
// - sensor or internal reference only in high-speed main mode.
// - channel select bits 5 and 6 always written zero.
// - after internal source set, drop first result; change only when stopped.
// - limits written only when stopped, upper greater than lower.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module adwc_ctrl #(
  parameter logic [19:0] MODE1_ADDR = 20'h00000,
  parameter logic [19:0] PORT_ADDR = 20'h00000,
  parameter logic [15:0] TRIG_GAP_CYC = adwc_pkg::TRIG_GAP_DEF
) (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic srst, // sync reset, active high
  input wire logic [7:0] sw_addr, // host register offset
  input wire logic [31:0] sw_wdata, // host write data
  input wire logic sw_wr, // host write strobe
  input wire logic sw_rd, // host read strobe
  output logic [31:0] sw_rdata, // host read data, cycle after strobe
  output logic [19:0] dev_addr, // device address pins
  output logic [15:0] dev_wdata, // device write data pins
  output logic dev_wr, // device write enable
  output logic dev_rd, // device read enable
  input wire logic [15:0] dev_rdata, // device read data
  input wire logic dev_run, // conversion running pin
  input wire logic dev_power_on, // converter powered pin
  input wire logic dev_done_irq, // conversion done pin
  output logic dev_hw_trigger, // hardware trigger pulse
  output logic dev_stop_req // request for stop state
);
  typedef enum {ST_IDLE, ST_ACC} adwc_state_e;
  typedef enum {K_WR, K_FETCH, K_STOP, K_RESUME} adwc_kind_e;

  adwc_state_e st_q;
  adwc_kind_e kind_q;
  logic [7:0] m2_q;
  logic [7:0] ul_q;
  logic [7:0] ll_q;
  logic [7:0] ch_q;
  logic [7:0] tm_q;
  logic cfg_hoco_q;
  logic cfg_high_speed_q;
  logic stop_q;
  logic discard_q;
  logic fetch_pend_q;
  logic irq_prev_q;
  logic reject_q;
  logic res_valid_q;
  logic [9:0] result_q;
  logic [15:0] gap_q;
  logic trig_q;
  logic [31:0] rdata_q;
  logic [2:0] pins_s;
  logic run_s;
  logic pwr_s;
  logic irq_s;
  logic stopped;
  logic done_rise;
  logic port_busy;
  logic port_done;
  logic [15:0] port_rdata;
  logic cmd_go;
  logic [3:0] tgt;
  logic [7:0] cd;
  logic can_take;
  logic tgt_ok;
  logic cmd_acc;
  logic fetch_go;
  logic cmd_dev;
  logic dev_start;
  logic start_rd;
  logic [19:0] start_addr;
  logic [7:0] start_data;
  logic [7:0] ch_wr;
  logic gap_ok;
  logic [9:0] res_dec;
  logic res_rd;
  logic stat_clr;

  adwc_sync #(.WIDTH(3)) u_psync (
    .clk_sys(clk_sys),
    .srst(srst),
    .din({dev_done_irq, dev_power_on, dev_run}),
    .dout(pins_s)
  );

  adwc_dev_port #(.HOLD(adwc_pkg::ACC_HOLD_CYC)) u_port (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(dev_start),
    .is_rd(start_rd),
    .addr(start_addr),
    .wdata({8'h00, start_data}),
    .busy(port_busy),
    .done(port_done),
    .rdata(port_rdata),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_wr(dev_wr),
    .dev_rd(dev_rd),
    .dev_rdata(dev_rdata)
  );

  assign run_s = pins_s[0];
  assign pwr_s = pins_s[1];
  assign irq_s = pins_s[2];
  assign stopped = !run_s && !pwr_s;
  assign done_rise = irq_s && !irq_prev_q;

  assign cmd_go = sw_wr && (sw_addr == adwc_pkg::CMD_OFS);
  assign tgt = sw_wdata[3:0];
  assign cd = sw_wdata[15:8];
  // pending result blocks every command, so no write can spoil an unread result
  assign can_take = (st_q == ST_IDLE) && !fetch_pend_q && !port_busy;
  assign fetch_go = (st_q == ST_IDLE) && fetch_pend_q && !port_busy;
  assign ch_wr = {cd[7], 2'h0, cd[4:0]};
  assign gap_ok = !stop_q || (gap_q >= TRIG_GAP_CYC);

  // legality of each command against the converter's own restrictions
  always_comb begin
    tgt_ok = 1'b0;
    case (tgt)
      adwc_pkg::T_MODE2: begin
        tgt_ok = stopped && !stop_q && !cd[adwc_pkg::M2_WAKE] &&
          !(cd[adwc_pkg::M2_REFP1:adwc_pkg::M2_REFP0] == adwc_pkg::REFP_INTERNAL &&
          (ch_q[adwc_pkg::CH_ISS] || !cfg_high_speed_q));
      end
      adwc_pkg::T_UPPER: tgt_ok = stopped && (cd > ll_q);
      adwc_pkg::T_LOWER: tgt_ok = stopped && (cd < ul_q);
      adwc_pkg::T_CHAN: begin
        tgt_ok = (stopped || (cd[adwc_pkg::CH_ISS] == ch_q[adwc_pkg::CH_ISS])) &&
          !(cd[adwc_pkg::CH_ISS] && (!cfg_high_speed_q ||
          m2_q[adwc_pkg::M2_REFP1:adwc_pkg::M2_REFP0] == adwc_pkg::REFP_INTERNAL));
      end
      adwc_pkg::T_MODE1: tgt_ok = !stop_q;
      adwc_pkg::T_TRIGM: tgt_ok = stopped && !stop_q;
      adwc_pkg::T_PORT: tgt_ok = !stop_q;
      adwc_pkg::T_STOP: begin
        if (cd[0]) begin
          tgt_ok = !stop_q && stopped && cfg_hoco_q &&
            (tm_q[adwc_pkg::TM_MODE_HI:adwc_pkg::TM_MODE_LO] == adwc_pkg::TM_HW_WAIT) &&
            tm_q[adwc_pkg::TM_ONESHOT];
        end else begin
          tgt_ok = stop_q && stopped;
        end
      end
      adwc_pkg::T_TRIG: tgt_ok = gap_ok;
      default: tgt_ok = 1'b0;
    endcase
  end

  assign cmd_acc = cmd_go && can_take && tgt_ok;
  assign cmd_dev = cmd_acc && (tgt != adwc_pkg::T_TRIG);
  assign dev_start = fetch_go || cmd_dev;
  assign start_rd = fetch_go;

  always_comb begin
    start_addr = adwc_pkg::RES_ADDR;
    start_data = cd;
    if (!fetch_go) begin
      case (tgt)
        adwc_pkg::T_MODE2: start_addr = adwc_pkg::MODE2_ADDR;
        adwc_pkg::T_UPPER: start_addr = adwc_pkg::UPPER_ADDR;
        adwc_pkg::T_LOWER: start_addr = adwc_pkg::LOWER_ADDR;
        adwc_pkg::T_CHAN: begin
          start_addr = adwc_pkg::CHAN_ADDR;
          start_data = ch_wr;
        end
        adwc_pkg::T_MODE1: start_addr = MODE1_ADDR;
        adwc_pkg::T_TRIGM: start_addr = adwc_pkg::TRIGM_ADDR;
        adwc_pkg::T_PORT: start_addr = PORT_ADDR;
        adwc_pkg::T_STOP: begin
          // wake enable is set only here, just before stop, and cleared on resume
          start_addr = adwc_pkg::MODE2_ADDR;
          start_data = cd[0] ? (m2_q | 8'h04) : (m2_q & 8'hfb);
        end
        default: start_addr = adwc_pkg::RES_ADDR;
      endcase
    end
  end

  // left-justified result; in 8-bit mode the two low result bits are zero
  assign res_dec = port_rdata[15:adwc_pkg::RES_LSB];
  assign res_rd = sw_rd && (sw_addr == adwc_pkg::RESULT_OFS);
  assign stat_clr = sw_wr && (sw_addr == adwc_pkg::STAT_OFS) && sw_wdata[1];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= ST_IDLE;
      kind_q <= K_WR;
      m2_q <= adwc_pkg::MODE2_RST;
      ul_q <= adwc_pkg::UPPER_RST;
      ll_q <= adwc_pkg::LOWER_RST;
      ch_q <= adwc_pkg::CHAN_RST;
      tm_q <= adwc_pkg::TRIGM_RST;
      stop_q <= 1'b0;
      discard_q <= 1'b0;
    end else if (dev_start) begin
      st_q <= ST_ACC;
      kind_q <= fetch_go ? K_FETCH : (tgt == adwc_pkg::T_STOP) ?
        (cd[0] ? K_STOP : K_RESUME) : K_WR;
      if (!fetch_go) begin
        case (tgt)
          adwc_pkg::T_MODE2: m2_q <= cd;
          adwc_pkg::T_UPPER: ul_q <= cd;
          adwc_pkg::T_LOWER: ll_q <= cd;
          adwc_pkg::T_CHAN: begin
            ch_q <= ch_wr;
            if (ch_wr[adwc_pkg::CH_ISS] && !ch_q[adwc_pkg::CH_ISS]) begin
              discard_q <= 1'b1;
            end
          end
          adwc_pkg::T_TRIGM: tm_q <= cd;
          adwc_pkg::T_STOP: begin
            m2_q <= start_data;
            stop_q <= 1'b0;
          end
          default: m2_q <= m2_q;
        endcase
      end
    end else if (st_q == ST_ACC && port_done) begin
      st_q <= ST_IDLE;
      if (kind_q == K_STOP) begin
        stop_q <= 1'b1;
      end
      if (kind_q == K_FETCH) begin
        discard_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fetch_pend_q <= 1'b0;
      irq_prev_q <= 1'b0;
      reject_q <= 1'b0;
      res_valid_q <= 1'b0;
      result_q <= 10'h000;
      cfg_hoco_q <= 1'b0;
      cfg_high_speed_q <= 1'b0;
    end else begin
      irq_prev_q <= irq_s;
      // a done edge in the launch cycle wins over the clear
      fetch_pend_q <= done_rise || (fetch_pend_q && !fetch_go);
      reject_q <= (cmd_go && !cmd_acc) || (reject_q && !stat_clr);
      if (st_q == ST_ACC && port_done && kind_q == K_FETCH && !discard_q) begin
        res_valid_q <= 1'b1;
        result_q <= res_dec;
      end else if (res_rd) begin
        res_valid_q <= 1'b0;
      end
      if (sw_wr && sw_addr == adwc_pkg::CFG_OFS) begin
        cfg_hoco_q <= sw_wdata[0];
        cfg_high_speed_q <= sw_wdata[1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gap_q <= 16'h0000;
      trig_q <= 1'b0;
    end else begin
      trig_q <= cmd_acc && (tgt == adwc_pkg::T_TRIG);
      if (cmd_acc && tgt == adwc_pkg::T_TRIG) begin
        gap_q <= 16'h0000;
      end else if (gap_q != 16'hffff) begin
        gap_q <= gap_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= 32'h00000000;
    end else if (sw_rd) begin
      case (sw_addr)
        adwc_pkg::STAT_OFS: rdata_q <= {26'h0, stop_q, discard_q, fetch_pend_q,
          res_valid_q, reject_q, (st_q != ST_IDLE)};
        adwc_pkg::RESULT_OFS: rdata_q <= {22'h0, result_q};
        adwc_pkg::CFG_OFS: rdata_q <= {30'h0, cfg_high_speed_q, cfg_hoco_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign sw_rdata = rdata_q;
  assign dev_hw_trigger = trig_q;
  assign dev_stop_req = stop_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  mode2_stopped_a: assert property (dev_start && start_addr == adwc_pkg::MODE2_ADDR &&
    !fetch_go |-> stopped)
    else $error("mode2 written while converter active");
  wake_mode_a: assert property (dev_start && !fetch_go &&
    start_addr == adwc_pkg::MODE2_ADDR && start_data[adwc_pkg::M2_WAKE] |->
    tm_q[7:6] == 2'h3 && tm_q[5])
    else $error("wake enable outside hardware wait one-shot mode");
  wake_clock_a: assert property (dev_start && !fetch_go &&
    start_addr == adwc_pkg::MODE2_ADDR && start_data[adwc_pkg::M2_WAKE] |-> cfg_hoco_q)
    else $error("wake enable without on-chip oscillator");
  trig_gap_a: assert property ($rose(dev_hw_trigger) && stop_q |->
    $past(gap_q) >= TRIG_GAP_CYC)
    else $error("wake trigger interval too short");
  wake_stop_a: assert property (kind_q == K_STOP && st_q == ST_ACC && port_done |=>
    dev_stop_req && m2_q[adwc_pkg::M2_WAKE])
    else $error("stop request without wake enable set");
  fetch_first_a: assert property (cmd_dev && (tgt == adwc_pkg::T_CHAN ||
    tgt == adwc_pkg::T_MODE1 || tgt == adwc_pkg::T_PORT) |-> !fetch_pend_q)
    else $error("register written before result fetched");
  chan_rsv_a: assert property ($rose(dev_wr) && dev_addr == adwc_pkg::CHAN_ADDR |->
    dev_wdata[6:5] == 2'h0)
    else $error("channel reserved bits nonzero");
  limit_order_a: assert property ($rose(dev_wr) && dev_addr == adwc_pkg::UPPER_ADDR |->
    dev_wdata[7:0] > ll_q && stopped)
    else $error("upper limit not above lower limit");
  discard_first_a: assert property (st_q == ST_ACC && port_done && kind_q == K_FETCH &&
    discard_q && !res_valid_q |=> !res_valid_q && !discard_q)
    else $error("first result after source switch kept");
  iss_speed_a: assert property ($rose(dev_wr) && dev_addr == adwc_pkg::CHAN_ADDR &&
    dev_wdata[7] |-> cfg_high_speed_q)
    else $error("internal source outside high-speed mode");
endmodule : adwc_ctrl

// >>> verification/adwc_dev_model.sv
// adwc_dev_model: behavioural converter with its result and limit registers on the access pins.
// assumes the controller holds each access steady until it drops the strobe.
`timescale 1ns/10ps
module adwc_dev_model (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  input wire logic [19:0] dev_addr, // address pins
  input wire logic [15:0] dev_wdata, // write data pins
  input wire logic dev_wr, // write enable
  input wire logic dev_rd, // read enable
  output logic [15:0] dev_rdata, // read data
  output logic dev_run, // run level
  output logic dev_power_on, // power level
  output logic dev_done_irq, // done level
  input wire logic dev_hw_trigger, // trigger pulse
  input wire logic dev_stop_req, // stop state
  input wire logic conv_on, // bench: run and power
  input wire logic [9:0] sample // bench: next value
);
  logic [7:0] mode2_q, upper_q, lower_q, chan_q;
  logic [15:0] res_q, last_q;
  logic [3:0] conv_q, irq_q;
  wire [9:0] smp = mode2_q[adwc_pkg::M2_RES8] ? {sample[9:2], 2'h0} : sample;
  wire in_area = lower_q <= smp[9:2] && smp[9:2] <= upper_q;
  wire keep = mode2_q[adwc_pkg::M2_RCK] ? !in_area : in_area;
  // wake enable blocks plain starts, only a trigger in stop converts
  wire start = dev_hw_trigger && (!mode2_q[adwc_pkg::M2_WAKE] || dev_stop_req);
  wire [15:0] rd_val = dev_addr == adwc_pkg::RES_ADDR ? res_q :
    dev_addr == adwc_pkg::RESH_ADDR ? {8'h00, res_q[15:8]} : 16'h0000;
  wire wr2 = dev_wr && dev_addr == adwc_pkg::MODE2_ADDR;
  assign dev_run = conv_on;
  assign dev_power_on = conv_on;
  assign dev_done_irq = irq_q != 4'h0;
  // released bus shows the inverse of the last value so a stale read cannot match
  assign dev_rdata = dev_rd ? rd_val : ~last_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode2_q <= 8'h00;
      upper_q <= 8'hff;
      lower_q <= 8'h00;
      chan_q <= 8'h00;
      res_q <= 16'h0000;
      last_q <= 16'h0000;
      conv_q <= 4'h0;
      irq_q <= 4'h0;
    end else begin
      if (dev_rd) last_q <= rd_val;
      if (wr2) mode2_q <= dev_wdata[7:0];
      if (dev_wr && dev_addr == adwc_pkg::UPPER_ADDR) upper_q <= dev_wdata[7:0];
      if (dev_wr && dev_addr == adwc_pkg::LOWER_ADDR) lower_q <= dev_wdata[7:0];
      if (dev_wr && dev_addr == adwc_pkg::CHAN_ADDR) chan_q <= dev_wdata[7:0];
      irq_q <= irq_q != 4'h0 ? irq_q - 4'h1 : 4'h0;
      conv_q <= start ? 4'ha : (conv_q != 4'h0 ? conv_q - 4'h1 : 4'h0);
      // results failing the area check (outside when M2_RCK is clear, inside when it is set) leave both result registers alone
      if (conv_q == 4'h1 && keep) begin
        res_q <= {smp, 6'h00};
        irq_q <= 4'h8;
      end
    end
  end
endmodule : adwc_dev_model

// >>> verification/adwc_ctrl_test.sv
// adwc_ctrl_test: drives the host port of adwc_ctrl against the converter model.
// assumes adwc_dev_model is compiled beside it.
`timescale 1ns/10ps
module adwc_ctrl_test;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0, sw_rd = 1'b0, conv_on = 1'b0;
  logic [9:0] sample = 10'h000;
  logic [31:0] sw_rdata, rd;
  logic [19:0] dev_addr;
  logic [15:0] dev_wdata, dev_rdata;
  logic dev_wr, dev_rd, dev_run, dev_power_on, dev_done_irq, dev_hw_trigger, dev_stop_req;
  int failures = 0, compares = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  adwc_ctrl #(.TRIG_GAP_CYC(16'h0004)) i_dut (.clk_sys(clk_sys), .srst(srst),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_rdata(dev_rdata), .dev_run(dev_run), .dev_power_on(dev_power_on),
    .dev_done_irq(dev_done_irq), .dev_hw_trigger(dev_hw_trigger), .dev_stop_req(dev_stop_req));
  adwc_dev_model i_dev (.clk_sys(clk_sys), .srst(srst), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
    .dev_run(dev_run), .dev_power_on(dev_power_on), .dev_done_irq(dev_done_irq),
    .dev_hw_trigger(dev_hw_trigger), .dev_stop_req(dev_stop_req), .conv_on(conv_on),
    .sample(sample));
  task automatic complete_run;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  // waits out busy and a pending fetch, bounded
  task automatic cmd(input logic [3:0] t, input logic [7:0] d);
    sw_write(adwc_pkg::CMD_OFS, {16'h0000, d, 4'h0, t});
    for (int n = 0; n < 30; n++) begin
      sw_read(adwc_pkg::STAT_OFS, rd);
      if (rd[0] === 1'b0 && rd[3] === 1'b0) break;
    end
  endtask : cmd
  task automatic rej(input logic e);
    sw_read(adwc_pkg::STAT_OFS, rd);
    chk({31'h0, rd[1]}, {31'h0, e});
    sw_write(adwc_pkg::STAT_OFS, 32'h0000_0002);
  endtask : rej
  task automatic convert(input logic [9:0] s, input logic nw, input logic [9:0] r,
    input logic [9:0] dr);
    sample <= s;
    cmd(adwc_pkg::T_TRIG, 8'h00);
    for (int n = 0; n < 30 && rd[2] !== 1'b1; n++) sw_read(adwc_pkg::STAT_OFS, rd);
    chk({31'h0, rd[2]}, {31'h0, nw});
    sw_read(adwc_pkg::RESULT_OFS, rd);
    chk({22'h0, rd[9:0]}, {22'h0, r});
    chk({16'h0000, i_dev.res_q}, {16'h0000, dr, 6'h00});
  endtask : convert
  task automatic sc_reset;
    chk({i_dev.mode2_q, i_dev.upper_q, i_dev.lower_q, i_dev.chan_q}, 32'h00ff0000);
    chk({16'h0000, i_dev.res_q}, 32'h0000_0000);
    sw_read(adwc_pkg::STAT_OFS, rd);
    chk(rd, 32'h0000_0000);
  endtask : sc_reset
  task automatic sc_limits;
    cmd(adwc_pkg::T_UPPER, 8'h80);
    cmd(adwc_pkg::T_LOWER, 8'h40);
    chk({16'h0, i_dev.upper_q, i_dev.lower_q}, 32'h0000_8040);
    cmd(adwc_pkg::T_UPPER, 8'h40);
    rej(1'b1);
    cmd(adwc_pkg::T_LOWER, 8'h80);
    rej(1'b1);
    chk({16'h0, i_dev.upper_q, i_dev.lower_q}, 32'h0000_8040);
  endtask : sc_limits
  task automatic sc_range;
    convert(10'h140, 1'b1, 10'h140, 10'h140);
    convert(10'h3fc, 1'b0, 10'h140, 10'h140);
    convert(10'h200, 1'b1, 10'h200, 10'h200);
    convert(10'h0fc, 1'b0, 10'h200, 10'h200);
    cmd(adwc_pkg::T_MODE2, 8'h08);
    convert(10'h0fc, 1'b1, 10'h0fc, 10'h0fc);
    convert(10'h203, 1'b0, 10'h0fc, 10'h0fc);
  endtask : sc_range
  task automatic sc_res8;
    cmd(adwc_pkg::T_MODE2, 8'h09);
    convert(10'h3ff, 1'b1, 10'h3fc, 10'h3fc);
    cmd(adwc_pkg::T_MODE2, 8'h00);
  endtask : sc_res8
  task automatic sc_refuse;
    conv_on <= 1'b1;
    repeat (6) @(posedge clk_sys);
    cmd(adwc_pkg::T_MODE2, 8'h01);
    rej(1'b1);
    conv_on <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cmd(adwc_pkg::T_MODE2, 8'h04);
    rej(1'b1);
    chk({24'h0, i_dev.mode2_q}, 32'h0000_0000);
  endtask : sc_refuse
  task automatic sc_channel;
    logic [7:0] c;
    for (int i = 0; i < 13; i++) begin
      c = i < 8 ? 8'(i) : 8'(i + 8);
      cmd(adwc_pkg::T_CHAN, c | 8'h60);
      chk({24'h0, i_dev.chan_q}, {24'h0, c});
    end
  endtask : sc_channel
  task automatic sc_stop;
    cmd(adwc_pkg::T_TRIGM, 8'he0);
    cmd(adwc_pkg::T_STOP, 8'h01);
    rej(1'b1);
    chk({31'h0, dev_stop_req}, 32'h0);
    sw_write(adwc_pkg::CFG_OFS, 32'h0000_0003);
    cmd(adwc_pkg::T_STOP, 8'h01);
    chk({23'h0, dev_stop_req, i_dev.mode2_q}, 32'h0000_0104);
    convert(10'h150, 1'b1, 10'h150, 10'h150);
    cmd(adwc_pkg::T_STOP, 8'h00);
    chk({23'h0, dev_stop_req, i_dev.mode2_q}, 32'h0000_0000);
  endtask : sc_stop
  task automatic sc_internal;
    cmd(adwc_pkg::T_CHAN, 8'h80);
    chk({24'h0, i_dev.chan_q}, 32'h0000_0080);
    convert(10'h160, 1'b0, 10'h150, 10'h160);
    convert(10'h170, 1'b1, 10'h170, 10'h170);
  endtask : sc_internal
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    sc_reset();
    sc_limits();
    sc_range();
    sc_res8();
    sc_refuse();
    sc_channel();
    sc_stop();
    sc_internal();
    complete_run();
  end
endmodule : adwc_ctrl_test
